// File: src/sbm_boot_select.sv
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "sbm_cfg.svh"

// Overview of operation
// [RL1] Strap a high, b low enters serial write
// [RL2] Link strap high USB, low UART
// [RL3] Host holds framing strap until communication starts
// [RL4] Transmit pin low enables USB mode
// [RL5] UART mode drives data on transmit pin
// [RL6] UART mode receives data on framing pin
// [RL7] Pull-up control low connects, high disconnects
// [RL8] USB mode uses dedicated D+ and D-
// [RL9] Crystal source starts at 115200 bps
// [RL10] Start rate follows 4/8/16 MHz table
// [RL11] No oscillator present selects internal RC
// [RL12] RC starts 9600 then switches to 115200
// [RL13] Host should use crystal with security enabled
// [RL14] Unused pins keep user-mode initial states
// [RL15] Straps latched once at reset release
module sbm_boot_select (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Strap pins
  input  wire logic        boot_strap_a_i,
  input  wire logic        boot_strap_b_i,
  input  wire logic        link_select_strap_i,
  input  wire logic        framing_select_rx_pin_i,
  // Oscillator sense
  input  wire logic        osc_xtal_present_i,
  input  wire logic        osc_ext_present_i,
  input  wire logic [1:0]  osc_freq_code_i,
  // Transmit / USB select pin
  input  wire logic        tx_usb_select_pin_i,
  output logic             tx_usb_select_pin_o,
  output logic             tx_usb_select_pin_oe_n_o,
  // USB pins
  output logic             dplus_pullup_ctrl_n_o,
  input  wire logic        usb_dplus_pin_i,
  output logic             usb_dplus_pin_o,
  output logic             usb_dplus_pin_oe_n_o,
  input  wire logic        usb_dminus_pin_i,
  output logic             usb_dminus_pin_o,
  output logic             usb_dminus_pin_oe_n_o
);

  // ==========================================
  // Baud divisor lookup
  function automatic logic [15:0] baud_div(input sbm_pkg::sbm_clk_src_t src,
                                            input logic [1:0] code,
                                            input logic fast);
    logic [15:0] d;
    d = 16'(`SBM_DIV(`SBM_BAUD_FAST));
    unique case (src)
      sbm_pkg::SBM_SRC_XTAL: d = 16'(`SBM_DIV(`SBM_BAUD_FAST));
      sbm_pkg::SBM_SRC_EXT: begin
        unique case (code)
          2'h1:    d = 16'(`SBM_DIV(`SBM_BAUD_4M));
          2'h2:    d = 16'(`SBM_DIV(`SBM_BAUD_8M));
          2'h3:    d = 16'(`SBM_DIV(`SBM_BAUD_16M));
          default: d = 16'(`SBM_DIV(`SBM_BAUD_FAST));
        endcase
      end
      sbm_pkg::SBM_SRC_RC:
        d = fast ? 16'(`SBM_DIV(`SBM_BAUD_FAST)) : 16'(`SBM_DIV(`SBM_BAUD_RC));
      default: d = 16'(`SBM_DIV(`SBM_BAUD_FAST));
    endcase
    return d;
  endfunction : baud_div

  // ==========================================
  // Strap capture
  logic                  latched_reg;
  logic                  serial_reg;
  logic                  usb_reg;
  logic                  async_reg;
  sbm_pkg::sbm_clk_src_t src_reg;
  logic [1:0]            freq_reg;

  wire sbm_pkg::sbm_clk_src_t src_sense =
    osc_xtal_present_i ? sbm_pkg::SBM_SRC_XTAL :
    osc_ext_present_i  ? sbm_pkg::SBM_SRC_EXT  :
                         sbm_pkg::SBM_SRC_RC; // RL11

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      latched_reg <= 1'b0;
      serial_reg  <= 1'b0;
      usb_reg     <= 1'b0;
      async_reg   <= 1'b0;
      src_reg     <= sbm_pkg::SBM_SRC_RC;
      freq_reg    <= 2'h0;
    end else if (!latched_reg) begin // RL15
      latched_reg <= 1'b1;
      serial_reg  <= boot_strap_a_i && !boot_strap_b_i; // RL1
      usb_reg     <= link_select_strap_i && !tx_usb_select_pin_i; // RL2 RL4
      async_reg   <= framing_select_rx_pin_i; // RL3
      src_reg     <= src_sense;
      freq_reg    <= osc_freq_code_i;
    end
  end

  wire uart_mode = serial_reg && !usb_reg;
  wire usb_mode  = serial_reg && usb_reg;

  // ==========================================
  // Registers and bus
  sbm_pkg::sbm_ctrl_t   ctrl_reg;
  sbm_pkg::sbm_status_t status_w;
  logic                 ack_reg;
  logic [31:0]          rdata_reg;
  logic [31:0]          rdata_next;
  logic                 fast_reg;
  logic [15:0]          div_reg;

  wire req      = (avs_read_i || avs_write_i) && ack_reg;
  wire wr_fire  = avs_write_i && !avs_waitrequest_o;
  wire rd_fire  = avs_read_i && !avs_waitrequest_o;
  wire sel_ctl  = (avs_address_i == `SBM_OFS_CONTROL);
  wire sel_tx   = (avs_address_i == `SBM_OFS_TXDATA);
  wire sel_rx   = (avs_address_i == `SBM_OFS_RXDATA);
  wire wr_ctl   = wr_fire && sel_ctl && avs_byteenable_i[0];
  wire wr_tx    = wr_fire && sel_tx && avs_byteenable_i[0];
  wire rd_rx    = rd_fire && sel_rx;
  wire comm_on  = serial_reg && ctrl_reg.comm_start;
  wire uart_on  = uart_mode && async_reg && ctrl_reg.comm_start;

  // Request latched one cycle, answered the next
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ack_reg <= 1'b1;
    end else begin
      ack_reg <= !req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_reg <= sbm_pkg::sbm_ctrl_t'(`SBM_CTL_RESET);
    end else if (wr_ctl) begin
      ctrl_reg <= sbm_pkg::sbm_ctrl_t'(avs_writedata_i[`SBM_CTL_DMOUT:0]);
    end
  end

  // Fast rate sticks once requested with the RC source
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      fast_reg <= 1'b0;
      div_reg  <= 16'(`SBM_DIV(`SBM_BAUD_RC));
    end else begin
      fast_reg <= fast_reg || (ctrl_reg.baud_switch && src_reg == sbm_pkg::SBM_SRC_RC); // RL12
      div_reg  <= baud_div(src_reg, freq_reg, fast_reg); // RL9 RL10 RL12
    end
  end

  // ==========================================
  // UART transmitter
  logic [9:0] tx_shift_reg;
  logic [3:0] tx_cnt_reg;
  logic       tx_tick;
  wire        tx_busy  = (tx_cnt_reg != 4'h0);
  wire        tx_start = wr_tx && !tx_busy && uart_on;

  sbm_baud_tick u_tx_tick (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .run_i     (tx_busy),
    .restart_i (tx_start),
    .half_i    (1'b0),
    .div_i     (div_reg),
    .tick_o    (tx_tick)
  );

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tx_shift_reg <= 10'h3FF;
      tx_cnt_reg   <= 4'h0;
    end else if (tx_start) begin
      tx_shift_reg <= {1'b1, avs_writedata_i[7:0], 1'b0};
      tx_cnt_reg   <= `SBM_UART_BITS;
    end else if (tx_tick && tx_busy) begin
      tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
      tx_cnt_reg   <= tx_cnt_reg - 4'h1;
    end
  end

  // ==========================================
  // UART receiver
  logic       rx_prev_reg;
  logic       rx_busy_reg;
  logic [3:0] rx_idx_reg;
  logic [7:0] rx_shift_reg;
  logic [7:0] rx_data_reg;
  logic       rx_valid_reg;
  logic       rx_tick;
  wire        rx_in    = framing_select_rx_pin_i; // RL6
  wire        rx_start = uart_on && !rx_busy_reg && rx_prev_reg && !rx_in;
  wire        rx_last  = rx_tick && rx_busy_reg && (rx_idx_reg == `SBM_UART_BITS - 4'h1);
  wire        rx_done  = rx_last && rx_in;

  sbm_baud_tick u_rx_tick (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .run_i     (rx_busy_reg),
    .restart_i (rx_start),
    .half_i    (1'b1),
    .div_i     (div_reg),
    .tick_o    (rx_tick)
  );

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rx_prev_reg  <= 1'b1;
      rx_busy_reg  <= 1'b0;
      rx_idx_reg   <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_data_reg  <= 8'h00;
    end else begin
      rx_prev_reg <= rx_in;
      if (rx_start) begin
        rx_busy_reg <= 1'b1;
        rx_idx_reg  <= 4'h0;
      end else if (rx_tick && rx_busy_reg) begin
        rx_idx_reg <= rx_idx_reg + 4'h1;
        // False start bit aborts
        if ((rx_idx_reg == 4'h0 && rx_in) || rx_last) begin
          rx_busy_reg <= 1'b0;
        end
        if (rx_idx_reg != 4'h0 && !rx_last) begin
          rx_shift_reg <= {rx_in, rx_shift_reg[7:1]};
        end
        if (rx_done) begin
          rx_data_reg <= rx_shift_reg;
        end
      end
    end
  end

  // New byte wins over a read clear
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= rx_done || (rx_valid_reg && !rd_rx);
    end
  end

  // ==========================================
  // Read mux
  assign status_w = '{dm_in:       usb_dminus_pin_i,
                      dp_in:       usb_dplus_pin_i,
                      rx_valid:    rx_valid_reg,
                      tx_busy:     tx_busy,
                      comm_active: comm_on,
                      baud_fast:   fast_reg,
                      clk_src:     src_reg,
                      async_mode:  async_reg,
                      usb_mode:    usb_reg,
                      serial_mode: serial_reg};

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (avs_address_i)
      `SBM_OFS_STATUS:  rdata_next = 32'(status_w);
      `SBM_OFS_CONTROL: rdata_next = 32'(ctrl_reg);
      `SBM_OFS_RXDATA:  rdata_next = {24'h00_0000, rx_data_reg};
      `SBM_OFS_DIVISOR: rdata_next = {16'h0000, div_reg};
      default:          rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req) begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================
  // Pin drivers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin // RL14
      avs_waitrequest_o        <= 1'b1;
      avs_readdata_o           <= 32'h0000_0000;
      tx_usb_select_pin_o      <= 1'b1;
      tx_usb_select_pin_oe_n_o <= 1'b1;
      dplus_pullup_ctrl_n_o    <= 1'b1;
      usb_dplus_pin_o          <= 1'b0;
      usb_dplus_pin_oe_n_o     <= 1'b1;
      usb_dminus_pin_o         <= 1'b0;
      usb_dminus_pin_oe_n_o    <= 1'b1;
    end else begin
      avs_waitrequest_o        <= !req;
      avs_readdata_o           <= req ? rdata_next : rdata_reg;
      tx_usb_select_pin_o      <= tx_shift_reg[0]; // RL5
      tx_usb_select_pin_oe_n_o <= !uart_on; // RL5 RL14
      dplus_pullup_ctrl_n_o    <= !(usb_mode && ctrl_reg.pullup_on); // RL7
      usb_dplus_pin_o          <= ctrl_reg.dp_out; // RL8
      usb_dplus_pin_oe_n_o     <= !(usb_mode && ctrl_reg.usb_oe); // RL8
      usb_dminus_pin_o         <= ctrl_reg.dm_out; // RL8
      usb_dminus_pin_oe_n_o    <= !(usb_mode && ctrl_reg.usb_oe); // RL8
    end
  end

endmodule : sbm_boot_select

// File: src/sbm_cfg.svh
`ifndef SBM_CFG_SVH
`define SBM_CFG_SVH

// ==========================================
// Register offsets (byte addresses)
`define SBM_OFS_STATUS   8'h00
`define SBM_OFS_CONTROL  8'h04
`define SBM_OFS_TXDATA   8'h08
`define SBM_OFS_RXDATA   8'h0C
`define SBM_OFS_DIVISOR  8'h10

// ==========================================
// Control field positions
`define SBM_CTL_START    0
`define SBM_CTL_BAUDSW   1
`define SBM_CTL_PULLUP   2
`define SBM_CTL_USBOE    3
`define SBM_CTL_DPOUT    4
`define SBM_CTL_DMOUT    5
`define SBM_CTL_RESET    6'h00

// ==========================================
// Timing
`define SBM_CLK_HZ       200000000
`define SBM_BAUD_FAST    115200
`define SBM_BAUD_4M      9600
`define SBM_BAUD_8M      19200
`define SBM_BAUD_16M     38400
`define SBM_BAUD_RC      9600
`define SBM_DIV(b)       (`SBM_CLK_HZ / (b))
`define SBM_UART_BITS    4'hA

`endif

// File: src/sbm_pkg.sv
package sbm_pkg;

  typedef enum logic [1:0] {
    SBM_SRC_XTAL,
    SBM_SRC_EXT,
    SBM_SRC_RC
  } sbm_clk_src_t;

  typedef struct packed {
    logic         dm_in;
    logic         dp_in;
    logic         rx_valid;
    logic         tx_busy;
    logic         comm_active;
    logic         baud_fast;
    sbm_clk_src_t clk_src;
    logic         async_mode;
    logic         usb_mode;
    logic         serial_mode;
  } sbm_status_t;

  typedef struct packed {
    logic dm_out;
    logic dp_out;
    logic usb_oe;
    logic pullup_on;
    logic baud_switch;
    logic comm_start;
  } sbm_ctrl_t;

endpackage : sbm_pkg

// File: src/sbm_baud_tick.sv
`timescale 1ns/1ps
`include "sbm_cfg.svh"

module sbm_baud_tick (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Control
  input  wire logic        run_i,
  input  wire logic        restart_i,
  input  wire logic        half_i,
  input  wire logic [15:0] div_i,
  // Tick
  output logic             tick_o
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        tick_next;
  wire         at_zero = (cnt_reg == 16'h0000);

  assign cnt_next  = restart_i ? (half_i ? {1'b0, div_i[15:1]} : div_i - 16'h0001)
                   : !run_i    ? cnt_reg
                   : at_zero   ? div_i - 16'h0001
                   :             cnt_reg - 16'h0001;
  assign tick_next = run_i && !restart_i && at_zero;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_reg <= 16'h0000;
      tick_o  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_o  <= tick_next;
    end
  end

endmodule : sbm_baud_tick

// File: tb/sbm_boot_select_sva.sv
`timescale 1ns/1ps
module sbm_boot_select_chk (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        nrst_i,
  // Register bus
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Straps and pins
  input wire logic        boot_strap_a_i,
  input wire logic        boot_strap_b_i,
  input wire logic        link_select_strap_i,
  input wire logic        tx_usb_select_pin_i,
  input wire logic        tx_usb_select_pin_o,
  input wire logic        tx_usb_select_pin_oe_n_o,
  input wire logic        dplus_pullup_ctrl_n_o,
  input wire logic        usb_dplus_pin_oe_n_o,
  input wire logic        usb_dminus_pin_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================
  // Mode as latched at reset release
  logic nrst_q;
  logic ser_l;
  logic usb_l;
  always_ff @(posedge clk_i) begin
    nrst_q <= nrst_i;
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ser_l <= 1'b0;
      usb_l <= 1'b0;
    end else if (!nrst_q) begin
      ser_l <= boot_strap_a_i && !boot_strap_b_i;
      usb_l <= boot_strap_a_i && !boot_strap_b_i && link_select_strap_i && !tx_usb_select_pin_i;
    end
  end
  // ==========================================
  // Assertions
  AST_RST_IDLE: assert property (disable iff (1'b0)
    !nrst_i |=> avs_waitrequest_o && avs_readdata_o == 32'h0) else $error("bus busy in reset");
  AST_ONE_WAIT: assert property (
    $rose(avs_read_i) || $rose(avs_write_i) |=> !avs_waitrequest_o) else $error("no answer");
  AST_WAIT_PULSE: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer too long");
  AST_WAIT_IDLE: assert property (
    !avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer without request");
  AST_IDLE_PINS: assert property (
    !ser_l |-> tx_usb_select_pin_oe_n_o && usb_dplus_pin_oe_n_o && dplus_pullup_ctrl_n_o)
    else $error("pin driven outside serial write");
  AST_PULLUP_USB: assert property (
    !usb_l |-> dplus_pullup_ctrl_n_o) else $error("pull-up outside usb mode");
  AST_USB_PINS: assert property (
    !usb_l |-> usb_dplus_pin_oe_n_o && usb_dminus_pin_oe_n_o) else $error("usb pin driven");
  AST_TX_USB_FREE: assert property (
    usb_l |-> tx_usb_select_pin_oe_n_o) else $error("tx pin driven in usb mode");
  AST_START_BIT: assert property (
    $fell(tx_usb_select_pin_o) && !tx_usb_select_pin_oe_n_o |-> !tx_usb_select_pin_o [*8])
    else $error("start bit too short");
  COV_READ: cover property ($rose(avs_read_i));
  COV_PULLUP: cover property (usb_l && !dplus_pullup_ctrl_n_o);
  COV_TX: cover property ($fell(tx_usb_select_pin_o) && !tx_usb_select_pin_oe_n_o);
endmodule : sbm_boot_select_chk

bind sbm_boot_select sbm_boot_select_chk u_chk (.clk_i, .nrst_i, .avs_read_i, .avs_write_i,
  .avs_readdata_o, .avs_waitrequest_o, .boot_strap_a_i, .boot_strap_b_i, .link_select_strap_i,
  .tx_usb_select_pin_i, .tx_usb_select_pin_o, .tx_usb_select_pin_oe_n_o, .dplus_pullup_ctrl_n_o,
  .usb_dplus_pin_oe_n_o, .usb_dminus_pin_oe_n_o);

// File: tb/sbm_host_model.sv
`timescale 1ns/1ps
module sbm_host_model (
  // Clock
  input  wire logic clk_i,
  // Device transmit line as resolved on the wire
  input  wire logic tx_line_i,
  // Board straps and oscillator sense
  output logic       boot_strap_a_o,
  output logic       boot_strap_b_o,
  output logic       link_select_strap_o,
  output logic       framing_rx_o,
  output logic       tx_sel_o,
  output logic       xtal_o,
  output logic       ext_o,
  output logic [1:0] freq_code_o
);
  initial begin
    {boot_strap_a_o, boot_strap_b_o, link_select_strap_o, framing_rx_o} = 4'hF;
    {tx_sel_o, xtal_o, ext_o, freq_code_o} = 5'h10;
  end
  // ==========================================
  // Straps, framing held until traffic, crystal preferred
  task automatic setup(input logic [8:0] v);
    {boot_strap_a_o, boot_strap_b_o, link_select_strap_o, framing_rx_o, tx_sel_o,
     xtal_o, ext_o, freq_code_o} <= v;
  endtask : setup
  // ==========================================
  // 8N1 frames, LSB first
  task automatic send_byte(input logic [7:0] d, input int div);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      framing_rx_o <= f[i];
      repeat (div) @(posedge clk_i);
    end
  endtask : send_byte
  task automatic recv_byte(input int div, output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    d = 8'h00;
    while (tx_line_i !== 1'b0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    ok = n < 4000;
    repeat (div / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge clk_i);
      d[i] = tx_line_i;
    end
    repeat (div) @(posedge clk_i);
    ok = ok && tx_line_i === 1'b1;
  endtask : recv_byte
endmodule : sbm_host_model

// File: tb/sbm_boot_select_bench.sv
`timescale 1ns/1ps
`include "sbm_cfg.svh"
module sbm_boot_select_bench;
  logic        clk_i, nrst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [7:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic        boot_strap_a_i, boot_strap_b_i, link_select_strap_i, framing_select_rx_pin_i;
  logic        osc_xtal_present_i, osc_ext_present_i, tx_sel, tx_o, tx_oe_n, pu_n;
  logic [1:0]  osc_freq_code_i;
  logic        dp_o, dp_oe_n, dm_o, dm_oe_n;
  wire         tx_w = tx_oe_n ? tx_sel : tx_o;
  wire         dp_w = dp_oe_n ? !pu_n : dp_o;
  wire         dm_w = dm_oe_n ? 1'b0 : dm_o;
  int          n_fail, compares;

  sbm_boot_select DUT (.clk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o,
    .boot_strap_a_i, .boot_strap_b_i, .link_select_strap_i, .framing_select_rx_pin_i,
    .osc_xtal_present_i, .osc_ext_present_i, .osc_freq_code_i, .tx_usb_select_pin_i(tx_w),
    .tx_usb_select_pin_o(tx_o), .tx_usb_select_pin_oe_n_o(tx_oe_n), .dplus_pullup_ctrl_n_o(pu_n),
    .usb_dplus_pin_i(dp_w), .usb_dplus_pin_o(dp_o), .usb_dplus_pin_oe_n_o(dp_oe_n),
    .usb_dminus_pin_i(dm_w), .usb_dminus_pin_o(dm_o), .usb_dminus_pin_oe_n_o(dm_oe_n));

  sbm_host_model host (.clk_i, .tx_line_i(tx_w), .boot_strap_a_o(boot_strap_a_i),
    .boot_strap_b_o(boot_strap_b_i), .link_select_strap_o(link_select_strap_i),
    .framing_rx_o(framing_select_rx_pin_i), .tx_sel_o(tx_sel), .xtal_o(osc_xtal_present_i),
    .ext_o(osc_ext_present_i), .freq_code_o(osc_freq_code_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // ==========================================
  // Bus and check tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 64);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    chk("waitrequest", 32'h0, {31'h0, n >= 64});
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("readdata", e, q & m);
  endtask : rdc
  task automatic rst(input logic [8:0] v);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    host.setup(v);
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask : rst
  task automatic final_report();
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // ==========================================
  // Tests
  initial begin
    logic [7:0] b;
    logic       ok;
    int         baud;
    n_fail = 0;
    compares = 0;
    nrst_i = 1'b0;
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = 42'h0;
    rst(9'h138);
    rdc(8'h00, 32'hFFFFFFFF, 32'h05);
    rdc(8'h10, 32'hFFFFFFFF, `SBM_CLK_HZ / 115200);
    rdc(8'h20, 32'hFFFFFFFF, 32'h0);
    wr(8'h04, 32'h1);
    host.setup(9'h0B8);
    rdc(8'h00, 32'hFFFFFFFF, 32'h45);
    fork
      host.recv_byte(`SBM_CLK_HZ / 115200, b, ok);
      wr(8'h08, 32'hA5);
    join
    chk("tx_byte", 32'h1A5, {23'h0, ok, b});
    host.send_byte(8'h3C, `SBM_CLK_HZ / 115200);
    rdc(8'h00, 32'h100, 32'h100);
    rdc(8'h0C, 32'hFF, 32'h3C);
    for (int c = 0; c < 4; c++) begin
      baud = (c == 0) ? 115200 : (9600 << (c - 1));
      rst({7'h4D, c[1:0]});
      rdc(8'h00, 32'h18, 32'h08);
      rdc(8'h10, 32'hFFFFFFFF, `SBM_CLK_HZ / baud);
    end
    rst(9'h130);
    rdc(8'h00, 32'h18, 32'h10);
    rdc(8'h10, 32'hFFFFFFFF, `SBM_CLK_HZ / 9600);
    wr(8'h04, 32'h2);
    // Sticky fast flag, then divisor, each take one edge
    repeat (2) @(posedge clk_i);
    rdc(8'h10, 32'hFFFFFFFF, `SBM_CLK_HZ / 115200);
    rst(9'h14C);
    rdc(8'h00, 32'h7, 32'h3);
    wr(8'h04, 32'h3C);
    // Pins follow control one edge later; look after they settle
    repeat (2) @(posedge clk_i);
    chk("usb_pins", 32'h5, {27'h0, pu_n, dp_oe_n, dp_o, dm_oe_n, dm_o});
    rdc(8'h00, 32'h600, 32'h600);
    wr(8'h04, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("pullup_n", 32'h1, {31'h0, pu_n});
    rst(9'h038);
    rdc(8'h00, 32'h1, 32'h0);
    wr(8'h04, 32'h3D);
    repeat (2) @(posedge clk_i);
    chk("idle_pins", 32'hF, {28'h0, tx_oe_n, dp_oe_n, dm_oe_n, pu_n});
    final_report();
  end
  initial begin
    #400000;
    n_fail++;
    final_report();
  end
endmodule : sbm_boot_select_bench
